// *** hw/ser_top.sv ***
// Operation
// - Instrument reset command leaves every status part unchanged.
// - Part queries return the part content as 0 to 32767, 15 bits; queue queries return 16-bit entries.
// - Condition part follows live activity; reading it never clears it.
// - Event part gathers qualified changes; reading it clears all bits except those newly hit in the read cycle.
// - Fall filter bit set: 1 to 0 condition change latches event.
// - Rise filter bit set: 0 to 1 condition change latches event.
// - Activity summary bit sees only events whose enable bit is set.
// - Fault summary bit sees only events its own enable mask selects.
// - Enabled events through summary bits can raise a service request.
// - Preset loads all rise filters with all ones.
// - Preset clears all fall filters to zero.
// - Preset clears both enable masks to zero.
// - A latched event bit stays set until the event part is read.
// - Queue query returns and removes oldest entry, zero when empty.

`include "ser_regs.svh"

module ser_top
  import ser_pkg::*;
#(
  parameter int W = `SER_W,
  parameter int QDEPTH = `SER_QDEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire ser_cmd_t cmd_i,
  input wire logic [W-1:0] act_cond_i,
  input wire logic [W-1:0] flt_cond_i,
  input wire logic err_push_i,
  input wire logic [`SER_QW-1:0] err_code_i,
  output ser_rsp_t rsp_o,
  output logic act_sum_o,
  output logic flt_sum_o,
  output logic srq_o,
  output logic err_full_o
);

  localparam int PW = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;
  localparam int CW = PW + 1;

  if (W < 1 || W > `SER_W) begin : g_bad_w
    $error("ser_top: W out of range");
  end
  if (QDEPTH < 2 || (QDEPTH & (QDEPTH - 1)) != 0) begin : g_bad_q
    $error("ser_top: QDEPTH must be a power of two, at least 2");
  end

  // Command decode
  wire cv = cmd_valid_i;
  wire [W-1:0] wdata = cmd_i.data[W-1:0];
  wire preset = cv && cmd_i.op == SER_PRESET;
  wire act_en_wr = cv && cmd_i.op == SER_ACT_EN_WR;
  wire act_rise_wr = cv && cmd_i.op == SER_ACT_RISE_WR;
  wire act_fall_wr = cv && cmd_i.op == SER_ACT_FALL_WR;
  wire flt_en_wr = cv && cmd_i.op == SER_FLT_EN_WR;
  wire act_ev_rd = cv && cmd_i.op == SER_ACT_EV_RD;
  wire flt_ev_rd = cv && cmd_i.op == SER_FLT_EV_RD;
  wire act_cond_rd = cv && cmd_i.op == SER_ACT_COND_RD;
  wire flt_cond_rd = cv && cmd_i.op == SER_FLT_COND_RD;
  wire q_rd = cv && cmd_i.op == SER_QUEUE_RD;
  wire is_rd = cv && (cmd_i.op == SER_ACT_COND_RD ||
                      cmd_i.op == SER_ACT_EN_RD ||
                      cmd_i.op == SER_ACT_EV_RD ||
                      cmd_i.op == SER_ACT_FALL_RD ||
                      cmd_i.op == SER_ACT_RISE_RD ||
                      cmd_i.op == SER_FLT_COND_RD ||
                      cmd_i.op == SER_FLT_EN_RD ||
                      cmd_i.op == SER_FLT_EV_RD ||
                      cmd_i.op == SER_QUEUE_RD);

  logic [W-1:0] act_ev;
  logic [W-1:0] act_en;
  logic [W-1:0] act_rise;
  logic [W-1:0] act_fall;
  logic [W-1:0] flt_ev;
  logic [W-1:0] flt_en;
  logic act_sum;
  logic flt_sum;

  ser_group #(
    .W(W),
    .HAS_FILT(1'b1)
  ) u_act (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cond_i(act_cond_i),
    .wdata_i(wdata),
    .wr_en_i(act_en_wr),
    .wr_rise_i(act_rise_wr),
    .wr_fall_i(act_fall_wr),
    .preset_i(preset),
    .rd_clr_i(act_ev_rd),
    .event_o(act_ev),
    .enable_o(act_en),
    .rise_o(act_rise),
    .fall_o(act_fall),
    .summary_o(act_sum)
  );

  ser_group #(
    .W(W),
    .HAS_FILT(1'b0)
  ) u_flt (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cond_i(flt_cond_i),
    .wdata_i(wdata),
    .wr_en_i(flt_en_wr),
    .wr_rise_i(1'b0),
    .wr_fall_i(1'b0),
    .preset_i(preset),
    .rd_clr_i(flt_ev_rd),
    .event_o(flt_ev),
    .enable_o(flt_en),
    .rise_o(),
    .fall_o(),
    .summary_o(flt_sum)
  );

  // Error queue: ring of flip-flops, oldest entry at rd_ptr_r
  logic [`SER_QW-1:0] q_mem_r [QDEPTH];
  logic [PW-1:0] rd_ptr_r;
  logic [PW-1:0] wr_ptr_r;
  logic [CW-1:0] cnt_r;
  wire q_empty = cnt_r == '0;
  wire q_full = cnt_r == CW'(QDEPTH);
  wire q_pop = q_rd && !q_empty;
  // A full queue still accepts a push when the same cycle pops
  wire q_push = err_push_i && (!q_full || q_pop);
  wire [`SER_QW-1:0] q_head = q_empty ? `SER_ERR_NONE :
                              q_mem_r[rd_ptr_r];
  wire [CW-1:0] cnt_nxt = cnt_r + CW'(q_push) - CW'(q_pop);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ptr_r <= '0;
      wr_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      rd_ptr_r <= rd_ptr_r + PW'(q_pop);
      wr_ptr_r <= wr_ptr_r + PW'(q_push);
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (q_push) begin
      q_mem_r[wr_ptr_r] <= err_code_i;
    end
  end

  // Read selection, zero-extended to the response width
  wire [W-1:0] part_sel =
    (cmd_i.op == SER_ACT_COND_RD) ? act_cond_i :
    (cmd_i.op == SER_ACT_EN_RD)   ? act_en :
    (cmd_i.op == SER_ACT_EV_RD)   ? act_ev :
    (cmd_i.op == SER_ACT_FALL_RD) ? act_fall :
    (cmd_i.op == SER_ACT_RISE_RD) ? act_rise :
    (cmd_i.op == SER_FLT_COND_RD) ? flt_cond_i :
    (cmd_i.op == SER_FLT_EN_RD)   ? flt_en :
    (cmd_i.op == SER_FLT_EV_RD)   ? flt_ev : '0;
  wire [`SER_QW-1:0] rd_mux = q_rd ? q_head :
                              `SER_QW'(part_sel);

  ser_rsp_t rsp_r;
  ser_rsp_t rsp_nxt;
  assign rsp_nxt.valid = is_rd;
  assign rsp_nxt.data = is_rd ? rd_mux : '0;

  logic srq_r;
  logic full_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_r <= '0;
      srq_r <= 1'b0;
      full_r <= 1'b0;
    end else begin
      rsp_r <= rsp_nxt;
      srq_r <= act_sum | flt_sum;
      full_r <= cnt_nxt == CW'(QDEPTH);
    end
  end

  assign rsp_o = rsp_r;
  assign act_sum_o = act_sum;
  assign flt_sum_o = flt_sum;
  assign srq_o = srq_r;
  assign err_full_o = full_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_COND_RD: assert property (
    act_cond_rd |=> (rsp_o.valid &&
                     rsp_o.data == `SER_QW'($past(act_cond_i))))
    else $error("condition read returned wrong value");

  AST_FLT_COND_RD: assert property (
    flt_cond_rd && !flt_ev_rd |=> (rsp_o.data ==
                                  `SER_QW'($past(flt_cond_i))))
    else $error("fault condition read returned wrong value");

  AST_EV_RD_CLR: assert property (
    act_ev_rd && act_cond_i == u_act.prev_r
      |=> (rsp_o.data == `SER_QW'($past(act_ev)) &&
           act_ev == '0))
    else $error("event read did not return and clear");

  AST_EV_RD_KEEP: assert property (
    act_ev_rd && (act_cond_i & ~u_act.prev_r & act_rise) != '0
      |=> (act_ev != '0))
    else $error("event lost in read-clear cycle");

  AST_PART_RANGE: assert property (
    rsp_o.valid && !$past(q_rd) |-> rsp_o.data[`SER_QW-1] == 1'b0)
    else $error("part read above 32767");

  AST_QUEUE_EMPTY: assert property (
    q_rd && q_empty |=> (rsp_o.valid && rsp_o.data == `SER_ERR_NONE))
    else $error("empty queue did not return zero");

  AST_QUEUE_POP: assert property (
    q_rd && !q_empty && !err_push_i |=> (cnt_r == $past(cnt_r) - 1'b1))
    else $error("queue query did not remove an entry");

  AST_SRQ: assert property (
    (act_sum_o || flt_sum_o) |=> srq_o)
    else $error("summary did not raise service request");

  AST_FLT_MASK: assert property (
    (flt_en == '0) [*2] |-> !flt_sum_o)
    else $error("masked fault events reached summary");

  AST_ACT_MASK: assert property (
    ((act_ev & act_en) == '0) [*2] |-> !act_sum_o)
    else $error("masked activity events reached summary");

  AST_PRESET_RISE: assert property (
    preset |=> act_rise == W'(`SER_RISE_PRE) && act_en == '0
           && flt_en == '0 && act_fall == '0)
    else $error("preset did not restore filters and masks");

  AST_FALL_ZERO: assert property (
    preset ##1 !act_fall_wr [*3] |-> act_fall == '0)
    else $error("fall filter not held at zero after preset");

  AST_FLT_EV_RD: assert property (
    flt_ev_rd && flt_cond_i == u_flt.prev_r
      |=> (rsp_o.data == `SER_QW'($past(flt_ev)) &&
           flt_ev == '0))
    else $error("fault event read did not return and clear");

  AST_ACT_SUM_SET: assert property (
    (act_ev & act_en) != '0 |=> act_sum_o)
    else $error("enabled activity event did not reach summary");

  AST_FLT_SUM_SET: assert property (
    (flt_ev & flt_en) != '0 |=> flt_sum_o)
    else $error("enabled fault event did not reach summary");

  AST_SRQ_LOW: assert property (
    !act_sum_o && !flt_sum_o |=> !srq_o)
    else $error("service request raised without a summary");

  AST_RSP_IDLE: assert property (
    !is_rd |=> (!rsp_o.valid && rsp_o.data == '0))
    else $error("response shown without a query");

  AST_FULL: assert property (
    err_full_o == (cnt_r == CW'(QDEPTH)))
    else $error("queue full flag does not match fill level");

  AST_QUEUE_DROP: assert property (
    err_push_i && q_full && !q_pop |=> cnt_r == $past(cnt_r))
    else $error("push into a full queue changed its fill level");

  AST_RISE_WR: assert property (
    act_rise_wr |=> act_rise == $past(wdata))
    else $error("rise filter write did not land");

  AST_FALL_WR: assert property (
    act_fall_wr |=> act_fall == $past(wdata))
    else $error("fall filter write did not land");

  COV_RISE_EVENT: cover property (
    $rose(act_ev[0]) ##[1:20] act_ev_rd);

  COV_SRQ: cover property (act_en_wr ##[1:20] $rose(srq_o));

  COV_QUEUE_POP: cover property (err_push_i ##[1:10] q_pop);

  COV_PRESET: cover property (act_rise_wr ##[1:10] preset);

  COV_COLLIDE: cover property (
    act_ev_rd && u_act.rise_hit != '0);

endmodule // ser_top

// *** hw/ser_regs.svh ***
`ifndef SER_REGS_SVH
`define SER_REGS_SVH

// Width of one status part
`define SER_W 15
// Width of an error-queue entry
`define SER_QW 16

// Command codes accepted on the command port
`define SER_OP_NONE        4'h0
`define SER_OP_ACT_COND_RD 4'h1
`define SER_OP_ACT_EN_WR   4'h2
`define SER_OP_ACT_EN_RD   4'h3
`define SER_OP_ACT_EV_RD   4'h4
`define SER_OP_ACT_FALL_WR 4'h5
`define SER_OP_ACT_FALL_RD 4'h6
`define SER_OP_ACT_RISE_WR 4'h7
`define SER_OP_ACT_RISE_RD 4'h8
`define SER_OP_PRESET      4'h9
`define SER_OP_FLT_COND_RD 4'hA
`define SER_OP_FLT_EN_WR   4'hB
`define SER_OP_FLT_EN_RD   4'hC
`define SER_OP_FLT_EV_RD   4'hD
`define SER_OP_QUEUE_RD    4'hE

// Preset and power-on values
`define SER_RISE_PRE 15'h7FFF
`define SER_FALL_PRE 15'h0000
`define SER_EN_PRE   15'h0000
`define SER_ERR_NONE 16'h0000

// Default error-queue depth
`define SER_QDEPTH 4

`endif

// *** hw/ser_pkg.sv ***
`include "ser_regs.svh"

package ser_pkg;

  typedef enum logic [3:0] {
    SER_NOP         = `SER_OP_NONE,
    SER_ACT_COND_RD = `SER_OP_ACT_COND_RD,
    SER_ACT_EN_WR   = `SER_OP_ACT_EN_WR,
    SER_ACT_EN_RD   = `SER_OP_ACT_EN_RD,
    SER_ACT_EV_RD   = `SER_OP_ACT_EV_RD,
    SER_ACT_FALL_WR = `SER_OP_ACT_FALL_WR,
    SER_ACT_FALL_RD = `SER_OP_ACT_FALL_RD,
    SER_ACT_RISE_WR = `SER_OP_ACT_RISE_WR,
    SER_ACT_RISE_RD = `SER_OP_ACT_RISE_RD,
    SER_PRESET      = `SER_OP_PRESET,
    SER_FLT_COND_RD = `SER_OP_FLT_COND_RD,
    SER_FLT_EN_WR   = `SER_OP_FLT_EN_WR,
    SER_FLT_EN_RD   = `SER_OP_FLT_EN_RD,
    SER_FLT_EV_RD   = `SER_OP_FLT_EV_RD,
    SER_QUEUE_RD    = `SER_OP_QUEUE_RD
  } ser_op_t;

  typedef struct packed {
    ser_op_t op;
    logic [`SER_W-1:0] data;
  } ser_cmd_t;

  typedef struct packed {
    logic valid;
    logic [`SER_QW-1:0] data;
  } ser_rsp_t;

endpackage

// *** hw/ser_group.sv ***
`include "ser_regs.svh"

module ser_group
  import ser_pkg::*;
#(
  parameter int W = `SER_W,
  parameter bit HAS_FILT = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] cond_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic wr_en_i,
  input wire logic wr_rise_i,
  input wire logic wr_fall_i,
  input wire logic preset_i,
  input wire logic rd_clr_i,
  output logic [W-1:0] event_o,
  output logic [W-1:0] enable_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o,
  output logic summary_o
);

  if (W < 1 || W > `SER_W) begin : g_bad_w
    $error("ser_group: W out of range");
  end

  logic [W-1:0] prev_r;
  logic [W-1:0] ev_r;
  logic [W-1:0] en_r;
  logic summary_r;
  wire [W-1:0] rise_hit = ~prev_r & cond_i & rise_o;
  wire [W-1:0] fall_hit = prev_r & ~cond_i & fall_o;
  // A hit in the clearing cycle survives the clear
  wire [W-1:0] ev_nxt =
    (rd_clr_i ? '0 : ev_r) | rise_hit | fall_hit;
  wire [W-1:0] en_nxt = preset_i ? W'(`SER_EN_PRE) :
                        wr_en_i ? wdata_i : en_r;
  wire summary_nxt = |(ev_r & en_r);

  // Power-on only: no instrument reset path reaches these parts
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_r <= '0;
      ev_r <= '0;
      en_r <= W'(`SER_EN_PRE);
      summary_r <= 1'b0;
    end else begin
      prev_r <= cond_i;
      ev_r <= ev_nxt;
      en_r <= en_nxt;
      summary_r <= summary_nxt;
    end
  end

  if (HAS_FILT) begin : g_filt
    logic [W-1:0] rise_r;
    logic [W-1:0] fall_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        rise_r <= W'(`SER_RISE_PRE);
        fall_r <= W'(`SER_FALL_PRE);
      end else if (preset_i) begin
        rise_r <= W'(`SER_RISE_PRE);
        fall_r <= W'(`SER_FALL_PRE);
      end else begin
        if (wr_rise_i) begin
          rise_r <= wdata_i;
        end
        if (wr_fall_i) begin
          fall_r <= wdata_i;
        end
      end
    end
    assign rise_o = rise_r;
    assign fall_o = fall_r;
  end else begin : g_fixed
    // Fixed at preset values when the group has no filter parts
    assign rise_o = W'(`SER_RISE_PRE);
    assign fall_o = W'(`SER_FALL_PRE);
  end

  assign event_o = ev_r;
  assign enable_o = en_r;
  assign summary_o = summary_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_RISE_LATCH: assert property (
    (|rise_hit) |=> ((event_o & $past(rise_hit)) == $past(rise_hit)))
    else $error("rising change not latched");

  AST_FALL_LATCH: assert property (
    (|fall_hit) |=> ((event_o & $past(fall_hit)) == $past(fall_hit)))
    else $error("falling change not latched");

  AST_EV_HOLD: assert property (
    !rd_clr_i |=> ((event_o & $past(event_o)) == $past(event_o)))
    else $error("event bit lost without a read");

  AST_SUMMARY: assert property (
    ##1 (summary_o == $past(|(event_o & enable_o))))
    else $error("summary does not follow masked events");

  AST_PRESET: assert property (
    preset_i |=> (enable_o == '0 && fall_o == '0 && (&rise_o)))
    else $error("preset values not loaded");

endmodule // ser_group

// *** dv/ser_host.sv ***
module ser_host
  import ser_pkg::*;
(
  input wire logic clk_i,
  input wire ser_rsp_t rsp_i,
  output logic cmd_valid_o,
  output ser_cmd_t cmd_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '{op: SER_NOP, data: 15'h0000};
  end

  // Write data is a whole 15-bit part value, so it never exceeds 7FFF
  task automatic send(input ser_op_t op, input logic [14:0] data);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_o = '{op: op, data: data};
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_o = '{op: SER_NOP, data: ~data};
  endtask

  // Answer stands in the cycle after the command edge
  task automatic query(input ser_op_t op, output logic [15:0] val);
    send(op, 15'h0000);
    val = rsp_i.valid ? rsp_i.data : 16'hxxxx;
  endtask
endmodule // ser_host

// *** dv/tb_top.sv ***
module tb_top;
  import ser_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int QD = 4;
  logic clk_i;
  logic rst_n_i;
  logic cmd_valid;
  ser_cmd_t cmd;
  ser_rsp_t rsp;
  logic [14:0] act_cond;
  logic [14:0] flt_cond;
  logic err_push;
  logic [15:0] err_code;
  logic act_sum;
  logic flt_sum;
  logic srq;
  logic err_full;
  logic [15:0] v;
  int bad_count;
  int compares;

  ser_top #(.W(15), .QDEPTH(QD)) dut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid),
    .cmd_i(cmd),
    .act_cond_i(act_cond),
    .flt_cond_i(flt_cond),
    .err_push_i(err_push),
    .err_code_i(err_code),
    .rsp_o(rsp),
    .act_sum_o(act_sum),
    .flt_sum_o(flt_sum),
    .srq_o(srq),
    .err_full_o(err_full)
  );

  ser_host host (
    .clk_i(clk_i),
    .rsp_i(rsp),
    .cmd_valid_o(cmd_valid),
    .cmd_o(cmd)
  );

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input ser_op_t op, input logic [15:0] exp);
    host.query(op, v);
    check(v, exp);
  endtask

  task automatic flags(input logic a, input logic f, input logic s);
    check({13'h0000, act_sum, flt_sum, srq}, {13'h0000, a, f, s});
  endtask

  // Conditions change after a falling edge; summaries settle 4 edges on
  task automatic setc(input logic [14:0] a, input logic [14:0] f);
    @(negedge clk_i);
    act_cond = a;
    flt_cond = f;
    repeat (4) @(negedge clk_i);
  endtask

  task automatic push(input logic [15:0] code);
    @(negedge clk_i);
    err_push = 1'b1;
    err_code = code;
    @(negedge clk_i);
    err_push = 1'b0;
    err_code = ~code;
  endtask

  task automatic t_reset;
    rd(SER_ACT_EN_RD, 16'h0000);
    rd(SER_ACT_RISE_RD, 16'h7fff);
    rd(SER_ACT_FALL_RD, 16'h0000);
    rd(SER_FLT_EN_RD, 16'h0000);
    rd(SER_ACT_EV_RD, 16'h0000);
    flags(1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_rise_hold;
    setc(15'h0001, 15'h4000);
    rd(SER_ACT_COND_RD, 16'h0001);
    rd(SER_ACT_COND_RD, 16'h0001);
    rd(SER_FLT_COND_RD, 16'h4000);
    setc(15'h0000, 15'h0000);
    rd(SER_ACT_EV_RD, 16'h0001);
    rd(SER_ACT_EV_RD, 16'h0000);
    rd(SER_FLT_EV_RD, 16'h4000);
    rd(SER_FLT_EV_RD, 16'h0000);
  endtask

  task automatic t_fall;
    host.send(SER_ACT_RISE_WR, 15'h0000);
    host.send(SER_ACT_FALL_WR, 15'h0002);
    setc(15'h0002, 15'h0000);
    rd(SER_ACT_EV_RD, 16'h0000);
    setc(15'h0000, 15'h0000);
    rd(SER_ACT_EV_RD, 16'h0002);
  endtask

  task automatic t_preset;
    host.send(SER_ACT_EN_WR, 15'h5555);
    host.send(SER_FLT_EN_WR, 15'h2aaa);
    rd(SER_FLT_EN_RD, 16'h2aaa);
    rd(SER_ACT_FALL_RD, 16'h0002);
    host.send(SER_PRESET, 15'h0000);
    rd(SER_ACT_RISE_RD, 16'h7fff);
    rd(SER_ACT_FALL_RD, 16'h0000);
    rd(SER_ACT_EN_RD, 16'h0000);
    rd(SER_FLT_EN_RD, 16'h0000);
  endtask

  task automatic t_summary;
    host.send(SER_ACT_EN_WR, 15'h0004);
    host.send(SER_FLT_EN_WR, 15'h0100);
    setc(15'h0008, 15'h0200);
    flags(1'b0, 1'b0, 1'b0);
    setc(15'h000c, 15'h0200);
    flags(1'b1, 1'b0, 1'b1);
    rd(SER_ACT_EV_RD, 16'h000c);
    @(negedge clk_i);
    flags(1'b0, 1'b0, 1'b1);
    @(negedge clk_i);
    flags(1'b0, 1'b0, 1'b0);
    setc(15'h000c, 15'h0300);
    flags(1'b0, 1'b1, 1'b1);
    rd(SER_FLT_EV_RD, 16'h0300);
  endtask

  // New event lands on the same edge that takes the clearing read
  task automatic t_collide;
    fork
      rd(SER_ACT_EV_RD, 16'h0000);
      begin
        @(negedge clk_i);
        act_cond = 15'h002c;
      end
    join
    rd(SER_ACT_EV_RD, 16'h0020);
  endtask

  task automatic t_queue;
    for (int i = 0; i < QD; i++) begin
      push(16'h1000 + 16'(i));
    end
    @(negedge clk_i);
    check({15'h0000, err_full}, 16'h0001);
    push(16'hbeef);
    for (int i = 0; i < QD; i++) begin
      rd(SER_QUEUE_RD, 16'h1000 + 16'(i));
    end
    rd(SER_QUEUE_RD, 16'h0000);
    check({15'h0000, err_full}, 16'h0000);
  endtask

  task automatic conclude;
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    bad_count = 0;
    compares = 0;
    rst_n_i = 1'b0;
    act_cond = 15'h0000;
    flt_cond = 15'h0000;
    err_push = 1'b0;
    err_code = 16'h0000;
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_rise_hold();
    t_fall();
    t_preset();
    t_summary();
    t_collide();
    t_queue();
    conclude();
  end
endmodule // tb_top
